// ### logic/irq_defs.svh
// Offsets, field positions, reset values and line numbers of the interrupt block
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// Priority field layout
`define PRIO_LEVELS 4
`define PRIO_W 2
`define PRIO_PER_REG 4
`define PRIO_BYTE_STRIDE 8
`define PRIO_FIELD_LSB 6
`define PRIO_RESET 32'h0000_0000
`define PRIO_REG_COUNT 8

// Vector table
`define IRQ_VEC_OFFSET 6'h10
`define VEC_BASE 32'h0000_0000
`define VEC_STRIDE_LOG2 2
`define VEC_INIT_SP 6'h00
`define VEC_INIT_PC 6'h01
`define VEC_NMI 6'h02
`define VEC_HARD_FAULT 6'h03
`define VEC_SUPERVISOR_CALL 6'h0b
`define VEC_PEND_SERVICE_REQ 6'h0e
`define VEC_TICK_TIMER 6'h0f

// Request line assignment
`define LINE_XFER_CH0 0
`define LINE_XFER_CH1 1
`define LINE_XFER_CH2 2
`define LINE_XFER_CH3 3
`define LINE_FLASH_CTRL 5
`define LINE_POWER_MGMT 6
`define LINE_LEAKAGE_WAKE 7
`define LINE_TWO_WIRE0 8
`define LINE_TWO_WIRE1 9
`define LINE_SER_PERIPH0 10
`define LINE_SER_PERIPH1 11
`define LINE_SER_PORT0 12
`define LINE_SER_PORT1 13
`define LINE_SER_PORT2 14
`define LINE_CONVERTER 15
`define LINE_COMPARATOR 16
`define LINE_PWM_TIMER0 17
`define LINE_PWM_TIMER1 18
`define LINE_PWM_TIMER2 19
`define LINE_CAL_ALARM 20
`define LINE_CAL_SECONDS 21
`define LINE_PERIODIC_TIMER 22
`define LINE_CLOCK_GENERATOR 27
`define LINE_LOW_POWER_TIMER 28
`define LINE_PORT_A_DETECT 30
`define LINE_PORT_D_DETECT 31

// Wake lines beyond the request lines
`define WAKE_NMI_LINE 32
`define WAKE_RESET_PIN_LINE 33

// Register byte offsets
`define OFS_PRIO_FIRST 8'h00
`define OFS_PRIO_LAST 8'h1c
`define OFS_ENABLE 8'h20
`define OFS_PENDING 8'h24
`define OFS_WAKE_EN_LO 8'h28
`define OFS_WAKE_EN_HI 8'h2c
`define OFS_WAKE_STAT_LO 8'h30
`define OFS_WAKE_STAT_HI 8'h34
`define OFS_ACTIVE 8'h38

// Reset values
`define ENABLE_RESET 32'h0000_0000
`define WAKE_EN_RESET 34'h3_ffff_ffff

`endif

// ### logic/irq_pkg.sv
// Types shared by the interrupt priority, vector and wake block
package irq_pkg;

   typedef logic [1:0] prio_t;

   typedef logic [5:0] vec_num_t;

   // Answer towards the core: winning vector and its table address
   typedef struct packed
   {
      logic valid;
      vec_num_t number;
      logic [31:0] addr;
   } vec_ans_t;

   // Avalon-MM request as seen by the slave
   typedef struct packed
   {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avl_req_t;

endpackage

// ### logic/prio_reg.sv
// One priority register: four 2-bit fields, one per byte
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"
module prio_reg
   import irq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Write port
   input wire logic wr,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   // State
   output logic [31:0] rdata,
   output prio_t fields [`PRIO_PER_REG]
);

   prio_t field_q [`PRIO_PER_REG];

   genvar b;
   generate
      for (b = 0; b < `PRIO_PER_REG; b++)
      begin : g_field
         localparam int LSB = `PRIO_BYTE_STRIDE * b + `PRIO_FIELD_LSB;
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               field_q[b] <= prio_t'(`PRIO_RESET >> LSB);
            else if (wr && be[b])
               field_q[b] <= wdata[LSB +: `PRIO_W];
         end
         // Low six bits of each byte read as zero
         assign rdata[`PRIO_BYTE_STRIDE*b +: `PRIO_FIELD_LSB] = '0;
         assign rdata[LSB +: `PRIO_W] = field_q[b];
         assign fields[b] = field_q[b];
      end
   endgenerate

endmodule
`default_nettype wire

// ### logic/irq_priority_vector_wake.sv
// Interrupt priority, vector selection, NMI routing and stop-mode wake lines
//
// What this block does
// - Four priority levels; each request line has a two-bit priority field.
// - Field for line n starts at bit 8*(n mod 4)+6; other byte bits read zero.
// - Line n's field lives in priority register number n div 4.
// - Line number is vector minus sixteen; vector entries are four bytes apart from zero.
// - Fixed core slots: stack, PC, NMI, hard fault, call 11, pend 14, tick 15.
// - Lines 0-3 transfer channels, 5 flash, 6 power, 7 leakage wake; 4 unused.
// - Lines 8-9 two-wire, 10-11 serial periph, 12-14 serial ports, 15 converter, 16 comparator.
// - Lines 17-19 pwm, 20-21 calendar, 22 periodic, 27 clock gen, 28 timer, 30-31 ports.
// - All thirty-two request inputs exist; build-time disable mask is zero.
// - NMI comes from the active-low pin, only when the pin mux selects it.
// - The wake interface has exactly thirty-four lines.
// - Reset pin, power warnings, pin irqs, converter, comparator, address match wake.
// - Serial port 0, pwm, low-power timer, receive edges, calendar, NMI, slave mode wake.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"
module irq_priority_vector_wake
   import irq_pkg::*;
#(
   parameter int REQUEST_LINE_COUNT = 32,
   parameter int WAKE_LINE_COUNT = 34,
   parameter logic [31:0] IRQ_DISABLE_MASK = 32'h0000_0000
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Peripheral request lines, same clock
   input wire logic [31:0] IRQ_REQ,
   // NMI pin and its mux selection
   input wire logic NMI_PIN_B,
   input wire logic NMI_PIN_SEL,
   // Reset pin wake source
   input wire logic RESET_PIN_B,
   input wire logic RESET_PIN_LPO_SEL,
   // Core side
   input wire logic IRQ_ACK,
   output vec_ans_t VECTOR,
   output logic NMI_REQ,
   output logic IRQ,
   // Wake controller interface
   output logic [33:0] WAKE_LINES,
   output logic WAKE
);

   // Only the documented build can be served
   generate
      if (REQUEST_LINE_COUNT != 32 || WAKE_LINE_COUNT != 34)
      begin : g_bad_count
         $error("Line counts must be 32 request and 34 wake lines");
      end
      if (IRQ_DISABLE_MASK != 32'h0000_0000)
      begin : g_bad_mask
         $error("All request lines must stay enabled at build time");
      end
   endgenerate

   // Bus request bundle
   avl_req_t req;
   assign req.read = AVS_READ;
   assign req.write = AVS_WRITE;
   assign req.address = AVS_ADDRESS;
   assign req.writedata = AVS_WRITEDATA;
   assign req.byteenable = AVS_BYTEENABLE;

   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wr_fire;
   logic [31:0] en_q;
   logic [31:0] pend_q;
   logic [31:0] pend_d;
   logic [33:0] wake_en_q;
   logic [33:0] wake_q;
   logic [33:0] wake_d;
   logic [33:0] wake_cap;
   logic [1:0] nmi_sync_q;
   logic [1:0] rst_sync_q;
   logic nmi_q;
   logic irq_q;
   logic wake_any_q;
   vec_ans_t vec_q;
   vec_ans_t vec_d;
   logic [31:0] prio_rdata [`PRIO_REG_COUNT];
   prio_t prio_fields [`PRIO_REG_COUNT][`PRIO_PER_REG];
   prio_t prio_line [32];
   logic [31:0] active;
   logic win_found;
   logic [4:0] win_line;
   prio_t win_prio;
   logic prio_hit;
   logic [2:0] prio_idx;

   // ---------------- Bus slave ----------------
   // One wait cycle per access: read data settle before waitrequest drops,
   // so every access takes exactly two edges and needs no state machine.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         wait_q <= 1'b1;
      else if ((req.read || req.write) && wait_q)
         wait_q <= 1'b0;
      else
         wait_q <= 1'b1;
   end

   assign wr_fire = req.write && !wait_q;

   assign prio_hit = (req.address[1:0] == 2'b00) &&
                     (req.address >= `OFS_PRIO_FIRST) && (req.address <= `OFS_PRIO_LAST);
   assign prio_idx = req.address[4:2];

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (prio_hit)
         rdata_d = prio_rdata[prio_idx];
      else
      begin
         case (req.address)
            `OFS_ENABLE:
               rdata_d = en_q;
            `OFS_PENDING:
               rdata_d = pend_q;
            `OFS_WAKE_EN_LO:
               rdata_d = wake_en_q[31:0];
            `OFS_WAKE_EN_HI:
               rdata_d = {30'h0, wake_en_q[33:32]};
            `OFS_WAKE_STAT_LO:
               rdata_d = wake_q[31:0];
            `OFS_WAKE_STAT_HI:
               rdata_d = {30'h0, wake_q[33:32]};
            `OFS_ACTIVE:
               rdata_d = {25'h0, vec_q.valid, vec_q.number};
            default:
               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         rdata_q <= 32'h0000_0000;
      else if (req.read && wait_q)
         rdata_q <= rdata_d;
   end

   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;

   // ---------------- Priority registers ----------------
   genvar r;
   genvar f;
   generate
      for (r = 0; r < `PRIO_REG_COUNT; r++)
      begin : g_prio
         prio_reg u_prio
         (
            .clk(CLK),
            .rst_b(RST_B),
            .wr(wr_fire && prio_hit && (prio_idx == r)),
            .be(req.byteenable),
            .wdata(req.writedata),
            .rdata(prio_rdata[r]),
            .fields(prio_fields[r])
         );
         for (f = 0; f < `PRIO_PER_REG; f++)
         begin : g_line
            // Line r*4+f: register r, byte f
            assign prio_line[r*`PRIO_PER_REG + f] = prio_fields[r][f];
         end
      end
   endgenerate

   // ---------------- Enable (mask) register ----------------
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         en_q <= `ENABLE_RESET;
      else if (wr_fire && req.address == `OFS_ENABLE)
         en_q <= req.writedata;
   end

   // ---------------- Pending (sticky status) ----------------
   // Clear by writing one, or by the core taking the shown vector.
   // A request arriving in the clearing cycle is kept: the set wins.
   always_comb
   begin
      pend_d = pend_q;
      if (wr_fire && req.address == `OFS_PENDING)
         pend_d = pend_d & ~req.writedata;
      if (IRQ_ACK && vec_q.valid && !nmi_q)
         pend_d[win_line_q_idx()] = 1'b0;
      pend_d = pend_d | (IRQ_REQ & ~IRQ_DISABLE_MASK);
   end

   function automatic logic [4:0] win_line_q_idx();
      logic [5:0] line;
      line = vec_q.number - `IRQ_VEC_OFFSET;
      return line[4:0];
   endfunction

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         pend_q <= 32'h0000_0000;
      else
         pend_q <= pend_d;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         irq_q <= 1'b0;
      else
         irq_q <= |(pend_q & en_q);
   end

   assign IRQ = irq_q;

   // ---------------- Arbitration ----------------
   assign active = pend_q & en_q;

   // Scanning downward with <= lets the lower line win a tie
   always_comb
   begin
      win_found = 1'b0;
      win_line = 5'h00;
      win_prio = prio_t'(`PRIO_LEVELS - 1);
      for (int i = 31; i >= 0; i--)
      begin
         if (active[i] && (!win_found || prio_line[i] <= win_prio))
         begin
            win_found = 1'b1;
            win_prio = prio_line[i];
            win_line = 5'(i);
         end
      end
   end

   // ---------------- NMI from the pin ----------------
   // Pin is asynchronous: two flops before use
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         nmi_sync_q <= 2'b11;
         rst_sync_q <= 2'b11;
      end
      else
      begin
         nmi_sync_q <= {nmi_sync_q[0], NMI_PIN_B};
         rst_sync_q <= {rst_sync_q[0], RESET_PIN_B};
      end
   end

   // Without the mux selection the pin is an ordinary port pin
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         nmi_q <= 1'b0;
      else
         nmi_q <= !nmi_sync_q[1] && NMI_PIN_SEL;
   end

   assign NMI_REQ = nmi_q;

   // ---------------- Vector answer ----------------
   // NMI slot outranks every request line
   always_comb
   begin
      vec_d.valid = nmi_q || win_found;
      if (nmi_q)
         vec_d.number = `VEC_NMI;
      else
         vec_d.number = {1'b0, win_line} + `IRQ_VEC_OFFSET;
      vec_d.addr = `VEC_BASE + {24'h00_0000, vec_d.number, 2'b00};
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         vec_q <= '0;
      else
         vec_q <= vec_d;
   end

   assign VECTOR = vec_q;

   // ---------------- Wake lines ----------------
   // Sources able to wake from stop; lines not listed stay quiet there.
   // Clock-stays-enabled conditions belong to each peripheral.
   always_comb
   begin
      wake_cap = 34'h0_0000_0000;
      wake_cap[`LINE_POWER_MGMT] = 1'b1;
      wake_cap[`LINE_TWO_WIRE0] = 1'b1;
      wake_cap[`LINE_TWO_WIRE1] = 1'b1;
      wake_cap[`LINE_SER_PERIPH0] = 1'b1;
      wake_cap[`LINE_SER_PERIPH1] = 1'b1;
      wake_cap[`LINE_SER_PORT0] = 1'b1;
      wake_cap[`LINE_SER_PORT1] = 1'b1;
      wake_cap[`LINE_SER_PORT2] = 1'b1;
      wake_cap[`LINE_CONVERTER] = 1'b1;
      wake_cap[`LINE_COMPARATOR] = 1'b1;
      wake_cap[`LINE_PWM_TIMER0] = 1'b1;
      wake_cap[`LINE_PWM_TIMER1] = 1'b1;
      wake_cap[`LINE_PWM_TIMER2] = 1'b1;
      wake_cap[`LINE_CAL_ALARM] = 1'b1;
      wake_cap[`LINE_CAL_SECONDS] = 1'b1;
      wake_cap[`LINE_LOW_POWER_TIMER] = 1'b1;
      wake_cap[`LINE_PORT_A_DETECT] = 1'b1;
      wake_cap[`LINE_PORT_D_DETECT] = 1'b1;
      wake_cap[`WAKE_NMI_LINE] = 1'b1;
      wake_cap[`WAKE_RESET_PIN_LINE] = 1'b1;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         wake_en_q <= `WAKE_EN_RESET;
      else if (wr_fire && req.address == `OFS_WAKE_EN_LO)
         wake_en_q[31:0] <= req.writedata;
      else if (wr_fire && req.address == `OFS_WAKE_EN_HI)
         wake_en_q[33:32] <= req.writedata[1:0];
   end

   // Reset pin counts only while clocked from the low-power oscillator
   always_comb
   begin
      wake_d[31:0] = IRQ_REQ & ~IRQ_DISABLE_MASK;
      wake_d[`WAKE_NMI_LINE] = !nmi_sync_q[1] && NMI_PIN_SEL;
      wake_d[`WAKE_RESET_PIN_LINE] = !rst_sync_q[1] && RESET_PIN_LPO_SEL;
      wake_d = wake_d & wake_cap & wake_en_q;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wake_q <= 34'h0_0000_0000;
         wake_any_q <= 1'b0;
      end
      else
      begin
         wake_q <= wake_d;
         wake_any_q <= |wake_d;
      end
   end

   assign WAKE_LINES = wake_q;
   assign WAKE = wake_any_q;

endmodule
`default_nettype wire

// ### verification/irq_pvw_properties.sv
// Port-level properties of the interrupt priority, vector and wake block
`timescale 1ns/1ps
`default_nettype none
module irq_pvw_properties
   import irq_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Register bus
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   // Pins and core side
   input wire logic NMI_PIN_B,
   input wire logic NMI_PIN_SEL,
   input wire vec_ans_t VECTOR,
   input wire logic NMI_REQ,
   input wire logic IRQ,
   // Wake interface
   input wire logic [33:0] WAKE_LINES,
   input wire logic WAKE
);
   localparam logic [33:0] WAKE_CAP = 34'h3_d03f_ff40;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered");
   wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait low longer than one cycle");
   bus_idle_a: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("answer without request");
   vec_addr_a: assert property (VECTOR.valid |-> VECTOR.addr == {24'h0, VECTOR.number, 2'b00})
      else $error("vector address not four per slot");
   nmi_vector_a: assert property (NMI_REQ |=> VECTOR.valid && VECTOR.number == 6'h02)
      else $error("nmi not shown on its slot");
   nmi_select_a: assert property (!NMI_PIN_SEL [*3] |=> !NMI_REQ)
      else $error("nmi without pin function");
   nmi_pin_a: assert property (NMI_PIN_B [*4] |=> !NMI_REQ)
      else $error("nmi with pin released");
   // Vector lags the NMI request by one edge, so skip the edge after it drops
   irq_vector_a: assert property (IRQ && !NMI_REQ && !$past(NMI_REQ) |->
      VECTOR.valid && VECTOR.number >= 6'h10)
      else $error("request shown below slot sixteen");
   wake_any_a: assert property (WAKE == |WAKE_LINES)
      else $error("wake not the or of its lines");
   wake_source_a: assert property ((WAKE_LINES & ~WAKE_CAP) == 34'h0)
      else $error("wake from an incapable line");
   cover property (NMI_REQ);
   cover property (IRQ ##1 !IRQ);
   cover property (WAKE_LINES[33]);
endmodule
`default_nettype wire

// ### verification/irq_periph_core_model.sv
// Behavioural peripherals pulsing request lines and a core acknowledging vectors
`timescale 1ns/1ps
`default_nettype none
module irq_periph_core_model
   import irq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Commands from the bench
   input wire logic [31:0] fire,
   input wire logic ack_go,
   // Core view of the controller
   input wire vec_ans_t vector,
   input wire logic nmi_req,
   // Towards the controller
   output logic [31:0] irq_req,
   output logic irq_ack
);
   // Events are one-cycle pulses unless the bench holds fire
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         irq_req <= 32'h0;
      else
         irq_req <= fire;
   // The NMI is never acknowledged here, it has no pending bit
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         irq_ack <= 1'b0;
      else
         irq_ack <= ack_go && vector.valid && !nmi_req;
endmodule
`default_nettype wire

// ### verification/tb_irq_priority_vector_wake.sv
// Self-checking bench for the interrupt priority, vector and wake block
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_vector_wake;
   import irq_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, ack_go = 1'b0;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0, fire = 32'h0, readdata, irq_req;
   logic [3:0] byteenable = 4'hf;
   logic nmi_pin_b = 1'b1, nmi_sel = 1'b0, reset_pin_b = 1'b1, lpo_sel = 1'b0;
   logic waitrequest, irq_ack, nmi_req, irq, wake;
   logic [33:0] wake_lines;
   vec_ans_t vector;
   int mismatches = 0;
   int checked = 0;
   int i;
   always #5 clk = ~clk;
   irq_priority_vector_wake dut (
      .CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
      .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable), .AVS_READDATA(readdata),
      .AVS_WAITREQUEST(waitrequest), .IRQ_REQ(irq_req), .NMI_PIN_B(nmi_pin_b),
      .NMI_PIN_SEL(nmi_sel), .RESET_PIN_B(reset_pin_b), .RESET_PIN_LPO_SEL(lpo_sel),
      .IRQ_ACK(irq_ack), .VECTOR(vector), .NMI_REQ(nmi_req), .IRQ(irq),
      .WAKE_LINES(wake_lines), .WAKE(wake));
   irq_periph_core_model model (
      .clk(clk), .rst_b(rst_b), .fire(fire), .ack_go(ack_go), .vector(vector),
      .nmi_req(nmi_req), .irq_req(irq_req), .irq_ack(irq_ack));
   task automatic check(input logic [38:0] seen, input logic [38:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until wait is seen low, so slow answers are honoured
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      byteenable <= be;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      check(waitrequest, 0);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      check(q, exp);
   endtask
   task automatic pulse(input logic [31:0] m);
      fire <= m;
      @(posedge clk);
      fire <= 32'h0;
   endtask
   task automatic service(input logic [5:0] v);
      repeat (3) @(posedge clk);
      check(vector, {1'b1, v, 24'h0, v, 2'b00});
      ack_go <= 1'b1;
      @(posedge clk);
      ack_go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200us;
      mismatches++;
      end_sim();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h20, 32'h0);
      rd(8'h28, 32'hffff_ffff);
      rd(8'h2c, 32'h3);
      for (i = 0; i < 8; i++)
      begin
         rd(8'(4 * i), 32'h0);
         wr(8'(4 * i), 32'hffff_ffff);
         rd(8'(4 * i), 32'hc0c0_c0c0);
      end
      wr(8'h00, 32'h0, 4'h2);
      rd(8'h00, 32'hc0c0_00c0);
      wr(8'h21, 32'h1);
      rd(8'h20, 32'h0);
      rd(8'h3c, 32'h0);
      // Masked line must pend without reaching the core
      pulse(32'h1);
      repeat (4) @(posedge clk);
      check(irq, 0);
      rd(8'h24, 32'h1);
      wr(8'h20, 32'hffff_ffff);
      repeat (2) @(posedge clk);
      check(irq, 1);
      wr(8'h24, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 0);
      for (i = 0; i < 32; i++)
      begin
         pulse(32'h1 << i);
         service(6'(i + 16));
      end
      for (i = 0; i < 8; i++)
         wr(8'(4 * i), 32'hc0c0_c0c0);
      wr(8'h08, 32'hc0c0_00c0);
      pulse(32'h0000_0208);
      service(6'd25);
      service(6'd19);
      wr(8'h0c, 32'h0);
      pulse(32'h0000_3000);
      service(6'd28);
      service(6'd29);
      wr(8'h1c, 32'h4080_0000);
      pulse(32'hc000_0000);
      service(6'd47);
      service(6'd46);
      check(irq, 0);
      wr(8'h20, 32'h0);
      fire <= 32'hffff_ffff;
      reset_pin_b <= 1'b0;
      lpo_sel <= 1'b1;
      repeat (6) @(posedge clk);
      check(wake_lines, 34'h2_d03f_ff40);
      check(wake, 1);
      rd(8'h30, 32'hd03f_ff40);
      rd(8'h34, 32'h2);
      wr(8'h28, 32'h0);
      wr(8'h2c, 32'h0);
      repeat (2) @(posedge clk);
      check(wake_lines, 0);
      fire <= 32'h0;
      reset_pin_b <= 1'b1;
      wr(8'h24, 32'hffff_ffff);
      wr(8'h2c, 32'h3);
      nmi_pin_b <= 1'b0;
      repeat (6) @(posedge clk);
      check(nmi_req, 0);
      nmi_sel <= 1'b1;
      repeat (6) @(posedge clk);
      check(nmi_req, 1);
      check(vector, {1'b1, 6'h02, 32'h8});
      rd(8'h38, 32'h42);
      check(wake_lines[32], 1);
      nmi_pin_b <= 1'b1;
      repeat (6) @(posedge clk);
      check(nmi_req, 0);
      end_sim();
   end
endmodule
bind irq_priority_vector_wake irq_pvw_properties chk (.CLK, .RST_B, .AVS_READ, .AVS_WRITE,
   .AVS_WAITREQUEST, .NMI_PIN_B, .NMI_PIN_SEL, .VECTOR, .NMI_REQ, .IRQ, .WAKE_LINES, .WAKE);
`default_nettype wire
